// >>> logic/pmuscr_regs.sv
// System and buck regulator control/status register bank of the PMU
// Behaviour
// - Battery monitor bit 7 unmasks (1) or masks (0) the battery-level interrupt.
// - Battery monitor bit 6 is read-only, 1 once a battery-level interrupt occurred.
// - Battery monitor bit 5 reads live: 1 while battery below threshold.
// - Battery monitor bits 3:0 hold the writable battery detect threshold.
// - Thermal register bit 7 unmasks (1) or masks (0) the thermal interrupt.
// - Thermal register bit 6 is read-only, 1 once a thermal interrupt occurred.
// - Buck control bit 7 enables (1) or disables (0) that regulator.
// - Buck control bit 2 selects anti-phase (1) or in-phase (0) switching.
// - Buck control bit 1 enables fault interrupts from that regulator.
// - Buck control bit 0 reads 1 while output is above power-good threshold.
// - Bucks two to four use the primary voltage field while select pin low.
// - Bucks two to four use the secondary voltage field while select pin high.
`timescale 1ns/1ns
`default_nettype none
module pmuscr_regs #(
  parameter int NUM_BUCKS = pmuscr_pkg::NUM_BUCKS,
  parameter int VSET_W = pmuscr_pkg::VSET_W,
  parameter int THRESH_W = pmuscr_pkg::THRESH_W
) (
  input wire logic ref_clk_in, // 20 MHz clock
  input wire logic reset_in, // Synchronous reset, active high
  input wire logic [7:0] reg_addr_in, // Register offset from the serial interface
  input wire logic [7:0] reg_wdata_in, // Write data
  input wire logic reg_write_in, // One-cycle write strobe
  input wire logic reg_read_in, // One-cycle read strobe
  output logic [7:0] reg_rdata_out, // Read data, valid with reg_rvalid_out
  output logic reg_rvalid_out, // One-cycle read answer
  input wire logic [THRESH_W-1:0] battery_level_code_in, // Digitised battery level, async
  input wire logic thermal_alert_in, // Thermal warning level, async
  input wire logic [NUM_BUCKS-1:0] power_good_in, // Per-buck power-good, async
  input wire logic [NUM_BUCKS-1:0] regulator_fault_in, // Per-buck fault level, async
  input wire logic voltage_select_pin_in, // Host voltage select pin, async
  output logic [THRESH_W-1:0] battery_threshold_select_out, // Threshold to analog monitor
  output logic [NUM_BUCKS-1:0] buck_enable_out, // Regulator enables
  output logic [NUM_BUCKS-1:0] buck_phase_out, // 1 = anti-phase switching
  output logic [(NUM_BUCKS-1)*VSET_W-1:0] buck_voltage_out, // Applied codes, bucks two..four
  output logic irq_out // Shared interrupt request, active high
);
  localparam int NV = NUM_BUCKS - 1;
  localparam int SYNC_W = THRESH_W + 2 + 2 * NUM_BUCKS;

  logic [SYNC_W-1:0] sync_bus;
  logic [THRESH_W-1:0] battery_level;
  logic thermal_alert;
  logic [NUM_BUCKS-1:0] power_good;
  logic [NUM_BUCKS-1:0] regulator_fault;
  logic voltage_select_pin;

  // Multi-bit level code may tear for a cycle while changing; comparator tolerates it
  pmuscr_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .async_in({battery_level_code_in, thermal_alert_in, voltage_select_pin_in,
               power_good_in, regulator_fault_in}),
    .sync_out(sync_bus)
  );

  assign {battery_level, thermal_alert, voltage_select_pin, power_good, regulator_fault} =
    sync_bus;

  // Control and status state
  logic battery_level_irq_unmask;
  logic battery_level_irq_flag;
  logic battery_below_threshold_live;
  logic battery_below_prev;
  logic battery_spare;
  logic [THRESH_W-1:0] battery_threshold_select;
  logic thermal_irq_unmask;
  logic thermal_irq_flag;
  logic thermal_prev;
  logic [pmuscr_pkg::THERM_SPARE_W-1:0] thermal_spare;
  logic [NUM_BUCKS-1:0] buck_enable;
  logic [NUM_BUCKS-1:0] buck_phase;
  logic [NUM_BUCKS-1:0] regulator_fault_irq_enable;
  logic [VSET_W-1:0] voltage_set_primary [NV];
  logic [VSET_W-1:0] voltage_set_secondary [NV];

  logic next_battery_level_irq_unmask;
  logic next_battery_level_irq_flag;
  logic next_battery_below_threshold_live;
  logic next_battery_spare;
  logic [THRESH_W-1:0] next_battery_threshold_select;
  logic next_thermal_irq_unmask;
  logic next_thermal_irq_flag;
  logic [pmuscr_pkg::THERM_SPARE_W-1:0] next_thermal_spare;
  logic [NUM_BUCKS-1:0] next_buck_enable;
  logic [NUM_BUCKS-1:0] next_buck_phase;
  logic [NUM_BUCKS-1:0] next_regulator_fault_irq_enable;
  logic [VSET_W-1:0] next_voltage_set_primary [NV];
  logic [VSET_W-1:0] next_voltage_set_secondary [NV];
  logic [(NUM_BUCKS-1)*VSET_W-1:0] next_buck_voltage;
  logic [7:0] next_rdata;
  logic next_irq;

  // Read strobes that clear the two sticky status flags
  logic rd_battery;
  logic rd_thermal;
  assign rd_battery = reg_read_in && reg_addr_in == pmuscr_pkg::ADDR_BATTERY_MONITOR;
  assign rd_thermal = reg_read_in && reg_addr_in == pmuscr_pkg::ADDR_THERMAL_IRQ;

  // Buck index owning a control register address, or -1
  function automatic int ctrl_index(input logic [7:0] addr);
    if (addr == pmuscr_pkg::ADDR_BUCK1_CONTROL) begin
      return 0;
    end else if (addr == pmuscr_pkg::ADDR_BUCK2_CONTROL) begin
      return 1;
    end else if (addr == pmuscr_pkg::ADDR_BUCK3_CONTROL) begin
      return 2;
    end else if (addr == pmuscr_pkg::ADDR_BUCK4_CONTROL) begin
      return 3;
    end else begin
      return -1;
    end
  endfunction

  // Voltage-set index (0 = buck two) for primary or secondary address, or -1
  function automatic int vset_index(input logic [7:0] addr, input logic secondary);
    if (addr == (secondary ? pmuscr_pkg::ADDR_BUCK2_VSET_SECONDARY
                           : pmuscr_pkg::ADDR_BUCK2_VSET_PRIMARY)) begin
      return 0;
    end else if (addr == (secondary ? pmuscr_pkg::ADDR_BUCK3_VSET_SECONDARY
                                    : pmuscr_pkg::ADDR_BUCK3_VSET_PRIMARY)) begin
      return 1;
    end else if (addr == (secondary ? pmuscr_pkg::ADDR_BUCK4_VSET_SECONDARY
                                    : pmuscr_pkg::ADDR_BUCK4_VSET_PRIMARY)) begin
      return 2;
    end else begin
      return -1;
    end
  endfunction

  always_comb begin
    int ci;
    int pi;
    int si;
    ci = ctrl_index(reg_addr_in);
    pi = vset_index(reg_addr_in, 1'b0);
    si = vset_index(reg_addr_in, 1'b1);

    next_battery_level_irq_unmask = battery_level_irq_unmask;
    next_battery_spare = battery_spare;
    next_battery_threshold_select = battery_threshold_select;
    next_thermal_irq_unmask = thermal_irq_unmask;
    next_thermal_spare = thermal_spare;
    next_buck_enable = buck_enable;
    next_buck_phase = buck_phase;
    next_regulator_fault_irq_enable = regulator_fault_irq_enable;
    next_voltage_set_primary = voltage_set_primary;
    next_voltage_set_secondary = voltage_set_secondary;

    next_battery_below_threshold_live = battery_level < battery_threshold_select;

    // Flags clear on read of their register; a new event in that cycle wins
    next_battery_level_irq_flag = battery_level_irq_flag;
    next_thermal_irq_flag = thermal_irq_flag;
    if (rd_battery) begin
      next_battery_level_irq_flag = 1'b0;
    end
    if (rd_thermal) begin
      next_thermal_irq_flag = 1'b0;
    end
    // Edge detect, so a battery staying low raises the flag only once
    if (battery_below_threshold_live && !battery_below_prev) begin
      next_battery_level_irq_flag = 1'b1;
    end
    if (thermal_alert && !thermal_prev) begin
      next_thermal_irq_flag = 1'b1;
    end

    if (reg_write_in) begin
      if (reg_addr_in == pmuscr_pkg::ADDR_BATTERY_MONITOR) begin
        next_battery_level_irq_unmask = reg_wdata_in[pmuscr_pkg::BAT_UNMASK_BIT];
        next_battery_spare = reg_wdata_in[pmuscr_pkg::BAT_SPARE_BIT];
        next_battery_threshold_select =
          reg_wdata_in[pmuscr_pkg::BAT_THRESH_LSB +: THRESH_W];
      end else if (reg_addr_in == pmuscr_pkg::ADDR_THERMAL_IRQ) begin
        next_thermal_irq_unmask = reg_wdata_in[pmuscr_pkg::THERM_UNMASK_BIT];
        next_thermal_spare = reg_wdata_in[pmuscr_pkg::THERM_SPARE_W-1:0];
      end else if (ci >= 0) begin
        next_buck_enable[ci] = reg_wdata_in[pmuscr_pkg::CTRL_ENABLE_BIT];
        next_buck_phase[ci] = reg_wdata_in[pmuscr_pkg::CTRL_PHASE_BIT];
        next_regulator_fault_irq_enable[ci] =
          reg_wdata_in[pmuscr_pkg::CTRL_FAULT_EN_BIT];
      end else if (pi >= 0) begin
        next_voltage_set_primary[pi] = reg_wdata_in[VSET_W-1:0];
      end else if (si >= 0) begin
        next_voltage_set_secondary[si] = reg_wdata_in[VSET_W-1:0];
      end
    end

    // Read mux; reserved bits and unmapped offsets read zero
    next_rdata = pmuscr_pkg::READ_UNMAPPED;
    if (reg_addr_in == pmuscr_pkg::ADDR_BATTERY_MONITOR) begin
      next_rdata[pmuscr_pkg::BAT_UNMASK_BIT] = battery_level_irq_unmask;
      next_rdata[pmuscr_pkg::BAT_FLAG_BIT] = battery_level_irq_flag;
      next_rdata[pmuscr_pkg::BAT_LIVE_BIT] = battery_below_threshold_live;
      next_rdata[pmuscr_pkg::BAT_SPARE_BIT] = battery_spare;
      next_rdata[pmuscr_pkg::BAT_THRESH_LSB +: THRESH_W] = battery_threshold_select;
    end else if (reg_addr_in == pmuscr_pkg::ADDR_THERMAL_IRQ) begin
      next_rdata[pmuscr_pkg::THERM_UNMASK_BIT] = thermal_irq_unmask;
      next_rdata[pmuscr_pkg::THERM_FLAG_BIT] = thermal_irq_flag;
      next_rdata[pmuscr_pkg::THERM_SPARE_W-1:0] = thermal_spare;
    end else if (ci >= 0) begin
      next_rdata[pmuscr_pkg::CTRL_ENABLE_BIT] = buck_enable[ci];
      next_rdata[pmuscr_pkg::CTRL_PHASE_BIT] = buck_phase[ci];
      next_rdata[pmuscr_pkg::CTRL_FAULT_EN_BIT] = regulator_fault_irq_enable[ci];
      next_rdata[pmuscr_pkg::CTRL_PGOOD_BIT] = power_good[ci];
    end else if (pi >= 0) begin
      next_rdata[VSET_W-1:0] = voltage_set_primary[pi];
    end else if (si >= 0) begin
      next_rdata[VSET_W-1:0] = voltage_set_secondary[si];
    end

    // Applied voltage follows the synchronised select pin
    for (int i = 0; i < NV; i++) begin
      next_buck_voltage[i*VSET_W +: VSET_W] = voltage_select_pin ?
        voltage_set_secondary[i] : voltage_set_primary[i];
    end

    // Flags stay latched until read; faults are levels and drop with the pin
    next_irq = (battery_level_irq_flag && battery_level_irq_unmask)
             || (thermal_irq_flag && thermal_irq_unmask)
             || |(regulator_fault & regulator_fault_irq_enable);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      battery_level_irq_unmask <= pmuscr_pkg::RST_BAT_UNMASK;
      battery_level_irq_flag <= 1'b0;
      battery_below_threshold_live <= 1'b0;
      battery_below_prev <= 1'b0;
      battery_spare <= pmuscr_pkg::RST_SPARE_BIT;
      battery_threshold_select <= pmuscr_pkg::RST_THRESHOLD;
      thermal_irq_unmask <= pmuscr_pkg::RST_THERM_UNMASK;
      thermal_irq_flag <= 1'b0;
      thermal_prev <= 1'b0;
      thermal_spare <= pmuscr_pkg::RST_THERM_SPARE;
      buck_enable <= pmuscr_pkg::RST_ENABLE;
      buck_phase <= pmuscr_pkg::RST_PHASE;
      regulator_fault_irq_enable <= pmuscr_pkg::RST_FAULT_EN;
      for (int i = 0; i < NV; i++) begin
        voltage_set_primary[i] <= pmuscr_pkg::RST_VSET;
        voltage_set_secondary[i] <= pmuscr_pkg::RST_VSET;
      end
      reg_rdata_out <= pmuscr_pkg::READ_UNMAPPED;
      reg_rvalid_out <= 1'b0;
      battery_threshold_select_out <= pmuscr_pkg::RST_THRESHOLD;
      buck_enable_out <= pmuscr_pkg::RST_ENABLE;
      buck_phase_out <= pmuscr_pkg::RST_PHASE;
      buck_voltage_out <= '0;
      irq_out <= 1'b0;
    end else begin
      battery_level_irq_unmask <= next_battery_level_irq_unmask;
      battery_level_irq_flag <= next_battery_level_irq_flag;
      battery_below_threshold_live <= next_battery_below_threshold_live;
      battery_below_prev <= battery_below_threshold_live;
      battery_spare <= next_battery_spare;
      battery_threshold_select <= next_battery_threshold_select;
      thermal_irq_unmask <= next_thermal_irq_unmask;
      thermal_irq_flag <= next_thermal_irq_flag;
      thermal_prev <= thermal_alert;
      thermal_spare <= next_thermal_spare;
      buck_enable <= next_buck_enable;
      buck_phase <= next_buck_phase;
      regulator_fault_irq_enable <= next_regulator_fault_irq_enable;
      voltage_set_primary <= next_voltage_set_primary;
      voltage_set_secondary <= next_voltage_set_secondary;
      reg_rdata_out <= reg_read_in ? next_rdata : pmuscr_pkg::READ_UNMAPPED;
      reg_rvalid_out <= reg_read_in;
      battery_threshold_select_out <= next_battery_threshold_select;
      buck_enable_out <= next_buck_enable;
      buck_phase_out <= next_buck_phase;
      buck_voltage_out <= next_buck_voltage;
      irq_out <= next_irq;
    end
  end
endmodule // pmuscr_regs
`default_nettype wire

// >>> logic/pmuscr_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module pmuscr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_in, // Module clock
  input wire logic reset_in, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain
  output logic [WIDTH-1:0] sync_out // Levels after two flops
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] next_stage_one;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_stage_one = async_in;
    next_sync = stage_one;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= next_stage_one;
      sync_out <= next_sync;
    end
  end
endmodule // pmuscr_sync
`default_nettype wire

// >>> pkg/pmuscr_pkg.sv
// Register map, field positions and reset values of the PMU system and buck registers
package pmuscr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_BUCKS = 4;
  localparam int VSET_W = 6;
  localparam int THRESH_W = 4;

  localparam logic [7:0] ADDR_BATTERY_MONITOR = 8'h00;
  localparam logic [7:0] ADDR_THERMAL_IRQ = 8'h01;
  localparam logic [7:0] ADDR_BUCK1_CONTROL = 8'h12;
  localparam logic [7:0] ADDR_BUCK2_VSET_PRIMARY = 8'h20;
  localparam logic [7:0] ADDR_BUCK2_VSET_SECONDARY = 8'h21;
  localparam logic [7:0] ADDR_BUCK2_CONTROL = 8'h22;
  localparam logic [7:0] ADDR_BUCK3_VSET_PRIMARY = 8'h30;
  localparam logic [7:0] ADDR_BUCK3_VSET_SECONDARY = 8'h31;
  localparam logic [7:0] ADDR_BUCK3_CONTROL = 8'h32;
  localparam logic [7:0] ADDR_BUCK4_VSET_PRIMARY = 8'h40;
  localparam logic [7:0] ADDR_BUCK4_VSET_SECONDARY = 8'h41;
  localparam logic [7:0] ADDR_BUCK4_CONTROL = 8'h42;

  // Battery monitor register fields
  localparam int BAT_UNMASK_BIT = 7;
  localparam int BAT_FLAG_BIT = 6;
  localparam int BAT_LIVE_BIT = 5;
  localparam int BAT_SPARE_BIT = 4;
  localparam int BAT_THRESH_LSB = 0;
  // Thermal register fields
  localparam int THERM_UNMASK_BIT = 7;
  localparam int THERM_FLAG_BIT = 6;
  localparam int THERM_SPARE_W = 6;
  // Buck control register fields
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_PHASE_BIT = 2;
  localparam int CTRL_FAULT_EN_BIT = 1;
  localparam int CTRL_PGOOD_BIT = 0;

  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  // Reset values
  localparam logic [THRESH_W-1:0] RST_THRESHOLD = 4'h0;
  localparam logic RST_BAT_UNMASK = 1'b0;
  localparam logic RST_THERM_UNMASK = 1'b0;
  localparam logic RST_SPARE_BIT = 1'b0;
  localparam logic [THERM_SPARE_W-1:0] RST_THERM_SPARE = 6'h00;
  localparam logic [NUM_BUCKS-1:0] RST_ENABLE = 4'h0;
  localparam logic [NUM_BUCKS-1:0] RST_PHASE = 4'h0;
  localparam logic [NUM_BUCKS-1:0] RST_FAULT_EN = 4'h0;
  localparam logic [VSET_W-1:0] RST_VSET = 6'h00;
endpackage

// >>> verification/pmuscr_host_model.sv
// Host model: register strobes and the voltage select pin
`timescale 1ns/1ns
`default_nettype none
module pmuscr_host_model (
  input wire logic ref_clk_in, // Clock
  input wire logic [7:0] rdata_in, // Read data
  input wire logic rvalid_in, // Read answer
  output logic [7:0] addr_out, // Offset
  output logic [7:0] wdata_out, // Write data
  output logic wr_out, // Write strobe
  output logic rd_out, // Read strobe
  output logic voltage_select_pin_out // Voltage select pin
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    voltage_select_pin_out = 1'b0;
  end
  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge ref_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rvalid_in ? rdata_in : 8'hXX;
  endtask
  task automatic set_voltage_select_pin(input logic b);
    @(posedge ref_clk_in);
    voltage_select_pin_out <= b;
  endtask
endmodule // pmuscr_host_model
`default_nettype wire

// >>> verification/pmuscr_regs_sva.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
`default_nettype none
module pmuscr_regs_chk (
  input wire logic ref_clk_in, // Clock
  input wire logic reset_in, // Reset
  input wire logic [7:0] reg_addr_in, // Offset
  input wire logic [7:0] reg_wdata_in, // Write data
  input wire logic reg_write_in, // Write strobe
  input wire logic reg_read_in, // Read strobe
  input wire logic [7:0] reg_rdata_out, // Read data
  input wire logic reg_rvalid_out, // Read answer
  input wire logic [3:0] battery_level_code_in, // Battery code
  input wire logic thermal_alert_in, // Alert
  input wire logic [3:0] power_good_in, // Power good
  input wire logic [3:0] regulator_fault_in, // Faults
  input wire logic voltage_select_pin_in, // Select pin
  input wire logic [3:0] battery_threshold_select_out, // Threshold
  input wire logic [3:0] buck_enable_out, // Enables
  input wire logic [3:0] buck_phase_out, // Phases
  input wire logic [17:0] buck_voltage_out, // Codes
  input wire logic irq_out // Interrupt
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  wire logic [3:0] hi = reg_addr_in[7:4];
  wire logic ctl = reg_read_in && reg_addr_in[3:0] == 4'h2 && hi inside {[4'h1:4'h4]};
  wire logic vst = reg_read_in && reg_addr_in[3:1] == 3'h0 && hi inside {[4'h2:4'h4]};
  wire logic rd0 = reg_read_in && reg_addr_in == 8'h00;
  wire logic rd12 = reg_read_in && reg_addr_in == 8'h12;
  wire logic [7:0] bat = {battery_level_code_in, battery_threshold_select_out};
  wire logic below = battery_level_code_in < battery_threshold_select_out;
  AST_THRESH_WR: assert property (reg_write_in && reg_addr_in == 8'h00 |=>
    battery_threshold_select_out == $past(reg_wdata_in[3:0])) else $error("threshold lost");
  AST_THRESH_RB: assert property (rd0 |=>
    reg_rdata_out[3:0] == $past(battery_threshold_select_out)) else $error("threshold read");
  AST_ENABLE_WR: assert property (reg_write_in && reg_addr_in == 8'h12 |=>
    buck_enable_out[0] == $past(reg_wdata_in[7])) else $error("enable lost");
  AST_ENABLE_RB: assert property (rd12 |=>
    reg_rdata_out[7] == $past(buck_enable_out[0])) else $error("enable read");
  AST_PHASE_WR: assert property (reg_write_in && reg_addr_in == 8'h42 |=>
    buck_phase_out[3] == $past(reg_wdata_in[2])) else $error("phase lost");
  AST_CTRL_RSVD: assert property (ctl |=> reg_rdata_out[6:3] == 4'h0)
    else $error("control reserved bits set");
  AST_VSET_RSVD: assert property (vst |=> reg_rdata_out[7:6] == 2'h0)
    else $error("voltage reserved bits set");
  AST_PGOOD: assert property ($stable(power_good_in[0]) [*6] ##0 rd12 |=>
    reg_rdata_out[0] == $past(power_good_in[0])) else $error("power good read");
  AST_LIVE: assert property ($stable(bat) [*6] ##0 rd0 |=>
    reg_rdata_out[5] == $past(below)) else $error("live compare read");
  cover property (irq_out);
  cover property (reg_rvalid_out && reg_rdata_out[6]);
  cover property ($changed(buck_voltage_out));
endmodule // pmuscr_regs_chk
bind pmuscr_regs pmuscr_regs_chk u_chk (
  .ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
  .reg_rdata_out, .reg_rvalid_out, .battery_level_code_in, .thermal_alert_in,
  .power_good_in, .regulator_fault_in, .voltage_select_pin_in,
  .battery_threshold_select_out, .buck_enable_out, .buck_phase_out, .buck_voltage_out,
  .irq_out
);
`default_nettype wire

// >>> verification/test_pmuscr_regs.sv
// Testbench of the PMU system and buck register bank
`timescale 1ns/1ns
`default_nettype none
module test_pmuscr_regs;
  logic ref_clk_in;
  logic reset_in;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_write_in;
  logic reg_read_in;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic [3:0] battery_level_code_in;
  logic thermal_alert_in;
  logic [3:0] power_good_in;
  logic [3:0] regulator_fault_in;
  logic voltage_select_pin_in;
  logic [3:0] battery_threshold_select_out;
  logic [3:0] buck_enable_out;
  logic [3:0] buck_phase_out;
  logic [17:0] buck_voltage_out;
  logic irq_out;
  int errors;
  int checks_done;
  int cycles;
  pmuscr_regs u_dut (
    .ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
    .reg_rdata_out, .reg_rvalid_out, .battery_level_code_in, .thermal_alert_in,
    .power_good_in, .regulator_fault_in, .voltage_select_pin_in,
    .battery_threshold_select_out, .buck_enable_out, .buck_phase_out, .buck_voltage_out,
    .irq_out
  );
  pmuscr_host_model u_host (
    .ref_clk_in, .rdata_in(reg_rdata_out), .rvalid_in(reg_rvalid_out),
    .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_write_in),
    .rd_out(reg_read_in), .voltage_select_pin_out(voltage_select_pin_in)
  );
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  task automatic end_sim;
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(d, e);
  endtask
  // Pin inputs cross two synchroniser flops, so waits leave margin
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic t_reset;
    logic [7:0] m [13] = '{8'h00, 8'h01, 8'h12, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31,
      8'h32, 8'h40, 8'h41, 8'h42, 8'h13};
    chk({buck_enable_out, buck_phase_out, battery_threshold_select_out, irq_out}, 0);
    u_host.wr(8'h13, 8'hFF);
    foreach (m[i]) rc(m[i], 8'h00);
  endtask
  task automatic t_ctrl;
    @(posedge ref_clk_in);
    power_good_in <= 4'h5;
    cyc(6);
    for (int i = 1; i <= 4; i++) begin
      u_host.wr(8'(i * 16 + 2), 8'hFF);
      rc(8'(i * 16 + 2), 8'h86 + 8'(i % 2));
    end
    chk({buck_enable_out, buck_phase_out}, 8'hFF);
    u_host.wr(8'h32, 8'h04);
    cyc(2);
    chk({buck_enable_out, buck_phase_out}, 8'hBF);
    rc(8'h32, 8'h05);
  endtask
  task automatic t_vset;
    for (int i = 2; i <= 4; i++) begin
      u_host.wr(8'(i * 16), 8'hC0 + 8'(i));
      u_host.wr(8'(i * 16 + 1), 8'hE8 + 8'(i));
      rc(8'(i * 16), 8'(i));
      rc(8'(i * 16 + 1), 8'h28 + 8'(i));
    end
    u_host.set_voltage_select_pin(1'b0);
    cyc(6);
    chk(buck_voltage_out, {6'h04, 6'h03, 6'h02});
    u_host.set_voltage_select_pin(1'b1);
    cyc(6);
    chk(buck_voltage_out, {6'h2C, 6'h2B, 6'h2A});
  endtask
  task automatic t_bat;
    @(posedge ref_clk_in);
    battery_level_code_in <= 4'h5;
    u_host.wr(8'h00, 8'h95);
    cyc(8);
    chk(battery_threshold_select_out, 4'h5);
    rc(8'h00, 8'h95);
    @(posedge ref_clk_in);
    battery_level_code_in <= 4'h4;
    cyc(8);
    chk(irq_out, 1'b1);
    rc(8'h00, 8'hF5);
    rc(8'h00, 8'hB5);
    cyc(3);
    chk(irq_out, 1'b0);
    @(posedge ref_clk_in);
    battery_level_code_in <= 4'h7;
    u_host.wr(8'h00, 8'h05);
    cyc(4);
    @(posedge ref_clk_in);
    battery_level_code_in <= 4'h3;
    cyc(8);
    chk(irq_out, 1'b0);
    rc(8'h00, 8'h65);
  endtask
  task automatic t_therm;
    u_host.wr(8'h01, 8'hBF);
    @(posedge ref_clk_in);
    thermal_alert_in <= 1'b1;
    cyc(8);
    chk(irq_out, 1'b1);
    rc(8'h01, 8'hFF);
    @(posedge ref_clk_in);
    thermal_alert_in <= 1'b0;
    cyc(4);
    rc(8'h01, 8'hBF);
    cyc(3);
    chk(irq_out, 1'b0);
    u_host.wr(8'h01, 8'h00);
    @(posedge ref_clk_in);
    thermal_alert_in <= 1'b1;
    cyc(8);
    chk(irq_out, 1'b0);
    rc(8'h01, 8'h40);
  endtask
  task automatic t_fault;
    u_host.wr(8'h12, 8'h80);
    u_host.wr(8'h42, 8'h80);
    @(posedge ref_clk_in);
    regulator_fault_in <= 4'h9;
    cyc(6);
    chk(irq_out, 1'b0);
    u_host.wr(8'h42, 8'h82);
    cyc(4);
    chk(irq_out, 1'b1);
    @(posedge ref_clk_in);
    regulator_fault_in <= 4'h0;
    cyc(6);
    chk(irq_out, 1'b0);
  endtask
  initial begin
    errors = 0;
    checks_done = 0;
    cycles = 0;
    reset_in = 1'b1;
    battery_level_code_in = 4'h0;
    thermal_alert_in = 1'b0;
    power_good_in = 4'h0;
    regulator_fault_in = 4'h0;
    repeat (5) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_ctrl();
    t_vset();
    t_bat();
    t_therm();
    t_fault();
    end_sim();
  end
endmodule // test_pmuscr_regs
`default_nettype wire
